// ---- reset_src_pkg.sv ----
/*
 * Constants, register map and types for the flash, clock and software
 * reset-source block. Assumes an APB master with 32-bit data and 12-bit
 * byte addresses, and one 25 MHz system clock.
 */

package reset_src_pkg;

   // =========================================================================
   // Register indices (byte address is four times the index)
   // =========================================================================
   localparam logic [7:0] PROGRAM_STORE_CONTROL_IDX = 8'h8F;
   localparam logic [7:0] RESET_SOURCE_IDX          = 8'h90;
   localparam logic [7:0] LOCK_ADDR_IDX             = 8'h91;
   localparam logic [7:0] RTC_CONTROL_IDX           = 8'h92;
   localparam logic [7:0] RTC_MATCH_IDX             = 8'h93;
   localparam logic [7:0] RTC_TIMER_IDX             = 8'h94;
   localparam logic [7:0] IRQ_STATUS_IDX            = 8'h95;
   localparam logic [7:0] IRQ_MASK_IDX              = 8'h96;

   // =========================================================================
   // Field positions
   // =========================================================================
   localparam int FLASH_WRITE_ENABLE_BIT      = 0;
   localparam int FLASH_PAGE_ERASE_ENABLE_BIT = 1;
   localparam int SOFTWARE_RESET_FLAG_BIT     = 4;
   localparam int RTC_RESET_FLAG_BIT          = 5;
   localparam int FLASH_ERROR_FLAG_BIT        = 6;
   localparam int RTC_RESET_ENABLE_BIT        = 7;
   localparam int RTC_MISSING_CLK_EN_BIT      = 0;
   localparam int RTC_ALARM_EN_BIT            = 1;
   localparam int IRQ_FLASH_ERR_BIT           = 0;
   localparam int IRQ_OSC_FAIL_BIT            = 1;
   localparam int IRQ_ALARM_BIT               = 2;
   localparam int IRQ_SOFT_RESET_BIT          = 3;
   localparam int IRQ_WIDTH                   = 4;

   // =========================================================================
   // Reset values
   // =========================================================================
   localparam logic [1:0]  PSC_RESET        = 2'h0;
   localparam logic [7:0]  RESET_SRC_RESET  = 8'h00;
   localparam logic [15:0] LOCK_ADDR_RESET  = 16'hFBFF;
   localparam logic [1:0]  RTC_CTRL_RESET   = 2'h0;
   localparam logic [31:0] RTC_MATCH_RESET  = 32'h0000_0000;
   localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;

   // =========================================================================
   // Timing
   // =========================================================================
   localparam int CLK_HZ                 = 25_000_000;
   localparam int RTC_MIN_FREQ_HZ        = 20_000;
   // Longest tolerated gap between clock edges, rounded down
   localparam int MISSING_CLK_CYCLES     = CLK_HZ / RTC_MIN_FREQ_HZ;
   localparam int RESET_HOLD_CYCLES      = 16;

   // =========================================================================
   // Types and helpers
   // =========================================================================
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_HOLD = 2'b01,
      SEQ_LAST = 2'b11
   } seq_state_t;

   function automatic logic [11:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'b00, idx, 2'b00};
   endfunction : byte_addr

endpackage : reset_src_pkg

// ---- reset_src_ctrl.sv ----
/*
 * Reset-source logic: flash access checking, program store control,
 * real-time clock oscillator-fail and alarm resets, software reset,
 * reset-cause flags and a held internal system reset. Assumes the core's
 * access strobes are on pclk; rtc_clk_pin and vdd_mon_en_pin are
 * asynchronous and are synchronised here.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module reset_src_ctrl
   import reset_src_pkg::*;
#(
   parameter int ADDR_W     = 16,
   parameter int HOLD_COUNT = RESET_HOLD_CYCLES,
   parameter int MISS_COUNT = MISSING_CLK_CYCLES
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Core accesses
   input  wire logic              fetch_valid,
   input  wire logic [ADDR_W-1:0] fetch_addr,
   input  wire logic              code_space_read_valid,
   input  wire logic [ADDR_W-1:0] code_space_read_addr,
   input  wire logic              data_move_external_wr,
   input  wire logic [ADDR_W-1:0] data_move_external_addr,
   input  wire logic [7:0]        data_move_external_data,
   // Security and supply status
   input  wire logic              sec_read_deny,
   input  wire logic              sec_write_deny,
   input  wire logic              vdd_mon_en_pin,
   input  wire logic              low_power_mode,
   // Real-time clock
   input  wire logic              rtc_clk_pin,
   // Flash and data memory requests
   output logic                   flash_write,
   output logic                   flash_page_erase,
   output logic      [ADDR_W-1:0] flash_addr,
   output logic      [7:0]        flash_data,
   output logic                   xram_write,
   // Reset and interrupt
   output logic                   system_reset_n,
   output logic                   irq
);

   if (ADDR_W < 8 || ADDR_W > 16) $error("ADDR_W must be 8..16");
   if (HOLD_COUNT < 2 || HOLD_COUNT > 255) $error("HOLD_COUNT must be 2..255");
   if (MISS_COUNT < 4 || MISS_COUNT > 65535) $error("MISS_COUNT must be 4..65535");

   function automatic logic above_lock(input logic [ADDR_W-1:0] a,
                                       input logic [15:0]       lock);
      above_lock = 16'(a) > lock;
   endfunction : above_lock

   // =========================================================================
   // Declarations
   // =========================================================================
   logic [1:0]        psc_q;
   logic              rtc_reset_enable_q;
   logic              flash_error_flag_q;
   logic              rtc_reset_flag_q;
   logic              software_reset_flag_q;
   logic [15:0]       lock_addr_q;
   logic [1:0]        rtc_ctrl_q;
   logic [31:0]       rtc_match_q;
   logic [31:0]       rtc_timer_q;
   logic [IRQ_WIDTH-1:0] irq_stat_q;
   logic [IRQ_WIDTH-1:0] irq_mask_q;
   logic [IRQ_WIDTH-1:0] irq_set;
   logic [2:0]        rtc_sync_q;
   logic [1:0]        vdd_sync_q;
   logic [15:0]       miss_cnt_q;
   logic              osc_fail_evt;
   logic              alarm_evt;
   logic              rtc_tick;
   seq_state_t        seq_q;
   logic [7:0]        hold_cnt_q;
   logic              in_reset;
   logic              flash_wr_err;
   logic              code_rd_err;
   logic              fetch_err;
   logic              flash_err_evt;
   logic              rtc_evt;
   logic              sw_evt;
   logic              apb_wr;
   logic [31:0]       rd_data;
   logic              rd_hit;

   assign in_reset = (seq_q != SEQ_IDLE);

   // =========================================================================
   // Synchronisers
   // =========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_sync_q <= 3'h0;
         vdd_sync_q <= 2'h0;
      end else begin
         rtc_sync_q <= {rtc_sync_q[1:0], rtc_clk_pin};
         vdd_sync_q <= {vdd_sync_q[0], vdd_mon_en_pin};
      end
   end

   // Edge seen only between second and third stages
   assign rtc_tick = rtc_sync_q[1] & ~rtc_sync_q[2];

   // =========================================================================
   // Flash access checking
   // =========================================================================
   always_comb begin
      flash_wr_err = 1'b0;
      if (data_move_external_wr && psc_q[FLASH_WRITE_ENABLE_BIT]) begin
         flash_wr_err = above_lock(data_move_external_addr, lock_addr_q)
                      | sec_write_deny
                      | ~vdd_sync_q[1];
      end
   end

   assign code_rd_err = code_space_read_valid &
                        (above_lock(code_space_read_addr, lock_addr_q) | sec_read_deny);
   assign fetch_err   = fetch_valid & above_lock(fetch_addr, lock_addr_q);
   assign flash_err_evt = ~in_reset & (flash_wr_err | code_rd_err | fetch_err);

   // Faulting write never reaches flash; plain writes go to data memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_write      <= 1'b0;
         flash_page_erase <= 1'b0;
         flash_addr       <= '0;
         flash_data       <= 8'h00;
         xram_write       <= 1'b0;
      end else begin
         flash_write      <= 1'b0;
         flash_page_erase <= 1'b0;
         xram_write       <= 1'b0;
         if (data_move_external_wr && !in_reset) begin
            if (!psc_q[FLASH_WRITE_ENABLE_BIT]) begin
               xram_write <= 1'b1;
            end else if (!flash_wr_err) begin
               flash_addr <= data_move_external_addr;
               flash_data <= data_move_external_data;
               if (psc_q[FLASH_PAGE_ERASE_ENABLE_BIT]) begin
                  flash_page_erase <= 1'b1;
               end else begin
                  flash_write      <= 1'b1;
               end
            end
         end
      end
   end

   // =========================================================================
   // Real-time clock: missing-clock detector, timer and alarm
   // =========================================================================
   // No low-power gating anywhere on this path so it still resets from sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_cnt_q <= 16'h0000;
      end else if (rtc_tick || !rtc_ctrl_q[RTC_MISSING_CLK_EN_BIT]) begin
         miss_cnt_q <= 16'h0000;
      end else if (miss_cnt_q != 16'(MISS_COUNT)) begin
         miss_cnt_q <= miss_cnt_q + 16'h0001;
      end
   end

   assign osc_fail_evt = rtc_ctrl_q[RTC_MISSING_CLK_EN_BIT] & ~rtc_tick &
                         (miss_cnt_q == 16'(MISS_COUNT - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_timer_q <= 32'h0000_0000;
      end else if (rtc_tick) begin
         rtc_timer_q <= rtc_timer_q + 32'h0000_0001;
      end
   end

   assign alarm_evt = rtc_ctrl_q[RTC_ALARM_EN_BIT] & rtc_tick &
                      (rtc_timer_q == rtc_match_q);

   assign rtc_evt = rtc_reset_enable_q & (osc_fail_evt | alarm_evt) & ~in_reset;

   // =========================================================================
   // APB slave
   // =========================================================================
   // No wait state: read data and error are registered in the setup phase, ready in the first access cycle
   assign apb_wr = psel & penable & pready & pwrite;
   assign sw_evt = apb_wr & (paddr == byte_addr(RESET_SOURCE_IDX)) &
                   pwdata[SOFTWARE_RESET_FLAG_BIT] & ~in_reset;

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (paddr)
         byte_addr(PROGRAM_STORE_CONTROL_IDX): rd_data = {30'h0, psc_q};
         byte_addr(RESET_SOURCE_IDX): begin
            rd_data[RTC_RESET_ENABLE_BIT]    = rtc_reset_enable_q;
            rd_data[FLASH_ERROR_FLAG_BIT]    = flash_error_flag_q;
            rd_data[RTC_RESET_FLAG_BIT]      = rtc_reset_flag_q;
            rd_data[SOFTWARE_RESET_FLAG_BIT] = software_reset_flag_q;
         end
         byte_addr(LOCK_ADDR_IDX):   rd_data = {16'h0000, lock_addr_q};
         byte_addr(RTC_CONTROL_IDX): rd_data = {30'h0, rtc_ctrl_q};
         byte_addr(RTC_MATCH_IDX):   rd_data = rtc_match_q;
         byte_addr(RTC_TIMER_IDX):   rd_data = rtc_timer_q;
         byte_addr(IRQ_STATUS_IDX):  rd_data = {28'h0, irq_stat_q};
         byte_addr(IRQ_MASK_IDX):    rd_data = {28'h0, irq_mask_q};
         default:                    rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr <= ~rd_hit;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // =========================================================================
   // Software-written registers
   // =========================================================================
   // Program store control also clears on the internal system reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_q <= PSC_RESET;
      end else if (in_reset) begin
         psc_q <= PSC_RESET;
      end else if (apb_wr && paddr == byte_addr(PROGRAM_STORE_CONTROL_IDX)) begin
         psc_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_reset_enable_q <= RESET_SRC_RESET[RTC_RESET_ENABLE_BIT];
      end else if (apb_wr && paddr == byte_addr(RESET_SOURCE_IDX)) begin
         rtc_reset_enable_q <= pwdata[RTC_RESET_ENABLE_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_addr_q <= LOCK_ADDR_RESET;
         rtc_ctrl_q  <= RTC_CTRL_RESET;
         rtc_match_q <= RTC_MATCH_RESET;
         irq_mask_q  <= IRQ_MASK_RESET;
      end else if (apb_wr) begin
         case (paddr)
            byte_addr(LOCK_ADDR_IDX):   lock_addr_q <= pwdata[15:0];
            byte_addr(RTC_CONTROL_IDX): rtc_ctrl_q  <= pwdata[1:0];
            byte_addr(RTC_MATCH_IDX):   rtc_match_q <= pwdata;
            byte_addr(IRQ_MASK_IDX):    irq_mask_q  <= pwdata[IRQ_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // =========================================================================
   // Reset-cause flags
   // =========================================================================
   // Flags survive the internal reset; only the newest cause stays set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_error_flag_q    <= 1'b0;
         rtc_reset_flag_q      <= 1'b0;
         software_reset_flag_q <= 1'b0;
      end else if (flash_err_evt) begin
         flash_error_flag_q    <= 1'b1;
         rtc_reset_flag_q      <= 1'b0;
         software_reset_flag_q <= 1'b0;
      end else if (rtc_evt) begin
         flash_error_flag_q    <= 1'b0;
         rtc_reset_flag_q      <= 1'b1;
         software_reset_flag_q <= 1'b0;
      end else if (sw_evt) begin
         flash_error_flag_q    <= 1'b0;
         rtc_reset_flag_q      <= 1'b0;
         software_reset_flag_q <= 1'b1;
      end
   end

   // =========================================================================
   // Interrupt status, write one to clear, set wins
   // =========================================================================
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_FLASH_ERR_BIT]  = flash_err_evt;
      irq_set[IRQ_OSC_FAIL_BIT]   = osc_fail_evt;
      irq_set[IRQ_ALARM_BIT]      = alarm_evt;
      irq_set[IRQ_SOFT_RESET_BIT] = sw_evt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
      end else if (apb_wr && paddr == byte_addr(IRQ_STATUS_IDX)) begin
         irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_WIDTH-1:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // =========================================================================
   // Internal reset sequencer
   // =========================================================================
   // Drives only the internal reset; the external pin is never an output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q          <= SEQ_IDLE;
         hold_cnt_q     <= 8'h00;
         system_reset_n <= 1'b1;
      end else begin
         case (seq_q)
            SEQ_IDLE: begin
               if (flash_err_evt || rtc_evt || sw_evt) begin
                  seq_q          <= SEQ_HOLD;
                  hold_cnt_q     <= 8'(HOLD_COUNT - 2);
                  system_reset_n <= 1'b0;
               end
            end
            SEQ_HOLD: begin
               if (hold_cnt_q == 8'h00) begin
                  seq_q <= SEQ_LAST;
               end else begin
                  hold_cnt_q <= hold_cnt_q - 8'h01;
               end
            end
            SEQ_LAST: begin
               seq_q          <= SEQ_IDLE;
               system_reset_n <= 1'b1;
            end
            default: begin
               seq_q          <= SEQ_IDLE;
               system_reset_n <= 1'b1;
            end
         endcase
      end
   end

endmodule : reset_src_ctrl

`default_nettype wire

// ---- reset_src_ctrl_asserts.sv ----
/* Port checker for reset_src_ctrl, bound to every instance.
   Assumes the lock address keeps its reset value. */
`timescale 1ns/1ns
`default_nettype none
module reset_src_ctrl_chk
   import reset_src_pkg::*;
#(
   parameter int ADDR_W     = 16,
   parameter int HOLD_COUNT = 16
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              fetch_valid,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic              code_space_read_valid,
   input wire logic [ADDR_W-1:0] code_space_read_addr,
   input wire logic              sec_read_deny,
   input wire logic              data_move_external_wr,
   input wire logic [ADDR_W-1:0] data_move_external_addr,
   input wire logic [7:0]        data_move_external_data,
   input wire logic              flash_write,
   input wire logic              flash_page_erase,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [7:0]        flash_data,
   input wire logic              xram_write,
   input wire logic              system_reset_n
);
   // ==========================================================
   // Reset length counter
   logic [8:0] low_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_q <= 9'h000;
      else low_q <= system_reset_n ? 9'h000 : low_q + 9'h001;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_FETCH: assert property (fetch_valid && fetch_addr > LOCK_ADDR_RESET
      && system_reset_n |=> !system_reset_n) else $error("fetch above lock kept running");
   AST_CREAD: assert property (code_space_read_valid && system_reset_n
      && (code_space_read_addr > LOCK_ADDR_RESET || sec_read_deny) |=> !system_reset_n)
      else $error("bad code read kept running");
   AST_NO_FLASH: assert property (data_move_external_wr
      && data_move_external_addr > LOCK_ADDR_RESET |=> !flash_write && !flash_page_erase)
      else $error("flash touched above lock");
   AST_WR_DATA: assert property (flash_write |-> $past(data_move_external_wr)
      && flash_data == $past(data_move_external_data) && !flash_page_erase
      && flash_addr == $past(data_move_external_addr)) else $error("flash write wrong");
   AST_ERASE: assert property (flash_page_erase |-> $past(data_move_external_wr)
      && !xram_write && flash_addr == $past(data_move_external_addr))
      else $error("page erase wrong");
   AST_ANSWER: assert property (data_move_external_wr && system_reset_n |=>
      (flash_write || flash_page_erase || xram_write || !system_reset_n))
      else $error("data move write lost");
   AST_HOLD: assert property ($rose(system_reset_n) |-> low_q == HOLD_COUNT)
      else $error("internal reset length wrong");
   AST_SWRST: assert property (psel && penable && pready && pwrite && pwdata[4]
      && paddr == byte_addr(RESET_SOURCE_IDX) && system_reset_n |=> !system_reset_n)
      else $error("software reset missing");
   AST_APB: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("bus answer timing wrong");
   AST_ERR: assert property (pslverr |-> pready) else $error("error without ready");
   cover property ($rose(system_reset_n));
   cover property (flash_page_erase);
   cover property (pslverr);
endmodule : reset_src_ctrl_chk
bind reset_src_ctrl reset_src_ctrl_chk #(.ADDR_W(ADDR_W), .HOLD_COUNT(HOLD_COUNT)) chk (.*);
`default_nettype wire

// ---- core_model.sv ----
/* Processor core model issuing one-cycle fetch, code read and data move pulses.
   Assumes calls start just after a rising pclk edge. */
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input  wire logic pclk,
   output logic      fetch_valid,
   output logic [15:0] fetch_addr,
   output logic      code_space_read_valid,
   output logic [15:0] code_space_read_addr,
   output logic      data_move_external_wr,
   output logic [15:0] data_move_external_addr,
   output logic [7:0] data_move_external_data
);
   // ==========================================================
   // Requests
   initial begin
      {fetch_valid, code_space_read_valid, data_move_external_wr} = 3'b000;
      {fetch_addr, code_space_read_addr, data_move_external_addr} = 48'h0;
      data_move_external_data = 8'h00;
   end
   task automatic issue(input int kind, input logic [15:0] a, input logic [7:0] d);
      @(posedge pclk);
      fetch_valid <= (kind == 0);
      code_space_read_valid <= (kind == 1);
      data_move_external_wr <= (kind == 2);
      {fetch_addr, code_space_read_addr, data_move_external_addr} <= {3{a}};
      data_move_external_data <= d;
      @(posedge pclk);
      // Released lines show inverted values, never the stale request
      {fetch_valid, code_space_read_valid, data_move_external_wr} <= 3'b000;
      {fetch_addr, code_space_read_addr, data_move_external_addr} <= {3{~a}};
      data_move_external_data <= ~d;
   endtask : issue
endmodule : core_model
`default_nettype wire

// ---- flash_rtc_soft_reset_sources_test.sv ----
/* Self-checking bench for reset_src_ctrl with a core model.
   Assumes the lock address stays at its reset value. */
`timescale 1ns/1ns
`default_nettype none
module flash_rtc_soft_reset_sources_test
   import reset_src_pkg::*;
;
   // ==========================================================
   // Signals and model state
   localparam int HOLD = 4;
   localparam logic [11:0] A_PSC = byte_addr(PROGRAM_STORE_CONTROL_IDX);
   localparam logic [11:0] A_SRC = byte_addr(RESET_SOURCE_IDX);
   localparam logic [11:0] A_RTC = byte_addr(RTC_CONTROL_IDX);
   localparam logic [11:0] A_ST = byte_addr(IRQ_STATUS_IDX);
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h25D4F2D8;
   logic pready, pslverr, sec_read_deny = 0, sec_write_deny = 0, vdd_mon_en_pin = 1;
   logic low_power_mode = 0, rtc_clk_pin = 0, rtc_run = 1, irq, system_reset_n;
   logic fetch_valid, code_space_read_valid, data_move_external_wr, xram_write;
   logic [15:0] fetch_addr, code_space_read_addr, data_move_external_addr, flash_addr, a;
   logic [7:0] data_move_external_data, flash_data;
   logic flash_write, flash_page_erase;
   logic [2:0] got;
   int fails = 0, checks_done = 0, cycles = 0, m_src = 0;
   int kind_t[7] = '{0, 0, 1, 1, 2, 2, 2};
   logic [15:0] addr_t[7] = '{16'hFBFF, 16'hFC00, 16'hFFFF, 16'h0100, 16'hFC00,
                              16'h0100, 16'h0100};
   reset_src_ctrl #(.HOLD_COUNT(HOLD), .MISS_COUNT(8)) DUT (.*);
   core_model u_core (.*);
   always #20 pclk = ~pclk;
   always @(posedge pclk) if (rtc_run) rtc_clk_pin <= ~rtc_clk_pin;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         conclude();
      end
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic core(input int kind, input logic [15:0] ad, input logic [7:0] d);
      u_core.issue(kind, ad, d);
      #1;
      got = {flash_write, flash_page_erase, xram_write};
      @(posedge pclk);
   endtask : core
   // Low cycles are counted from the first edge that sees reset low
   task automatic expect_rst(input string what, input int exp_low, input int cause, input int w);
      int n, low;
      n = 0;
      low = 0;
      while (system_reset_n === 1'b1 && n < w) begin @(posedge pclk); n++; end
      while (system_reset_n === 1'b0) begin low++; @(posedge pclk); end
      check(what, low, exp_low);
      if (cause >= 0) m_src = (m_src & 32'h80) | (1 << cause);
      apb(1'b0, A_SRC, 32'h0);
      check("reset source", rd, m_src);
   endtask : expect_rst
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_PSC, 32'h0); check("psc reset", rd, PSC_RESET);
      apb(1'b1, A_PSC, 32'hFF); apb(1'b0, A_PSC, 32'h0); check("psc bits", rd, 32'h3);
      apb(1'b0, byte_addr(LOCK_ADDR_IDX), 32'h0); check("lock", rd, LOCK_ADDR_RESET);
      apb(1'b0, 12'hFFC, 32'h0); check("unmapped", {rd[30:0], err}, 32'h1);
      lfsr = next_rand(lfsr);
      core(2, 16'h1200, lfsr[7:0]); check("erase", got, 3'b010);
      expect_rst("quiet", 0, -1, 4);
      apb(1'b1, A_PSC, 32'h1);
      lfsr = next_rand(lfsr);
      a = lfsr[15:0] & 16'h7FFF;
      core(2, a, lfsr[23:16]);
      check("write", {got, flash_addr, flash_data}, {3'b100, a, lfsr[23:16]});
      apb(1'b1, A_PSC, 32'h0);
      core(2, a, 8'h5A); check("xram", got, 3'b001);
      for (int i = 0; i < 7; i++) begin
         sec_read_deny <= (i == 3);
         sec_write_deny <= (i == 5);
         vdd_mon_en_pin <= (i != 6);
         apb(1'b1, A_PSC, 32'h1);
         core(kind_t[i], addr_t[i], 8'hA5); check("no flash", got, 3'b000);
         expect_rst("access", (i != 0) ? HOLD : 0, (i != 0) ? FLASH_ERROR_FLAG_BIT : -1,
                    4);
         apb(1'b0, A_PSC, 32'h0); check("psc after", rd, (i == 0));
      end
      {sec_read_deny, sec_write_deny, vdd_mon_en_pin} <= 3'b001;
      apb(1'b0, A_ST, 32'h0); check("status", rd, 32'h1);
      check("irq masked", irq, 1'b0);
      apb(1'b1, byte_addr(IRQ_MASK_IDX), 32'h1);
      repeat (2) @(posedge pclk); check("irq", irq, 1'b1);
      apb(1'b1, A_ST, 32'h1);
      repeat (2) @(posedge pclk); check("irq clear", irq, 1'b0);
      apb(1'b1, A_SRC, 32'h10);
      expect_rst("soft", HOLD, SOFTWARE_RESET_FLAG_BIT, 4);
      low_power_mode <= 1'b1;
      apb(1'b1, A_SRC, 32'h80); m_src = m_src | 32'h80;
      apb(1'b0, byte_addr(RTC_TIMER_IDX), 32'h0);
      apb(1'b1, byte_addr(RTC_MATCH_IDX), rd + 32'd20);
      apb(1'b1, A_RTC, 32'h2);
      expect_rst("alarm", HOLD, RTC_RESET_FLAG_BIT, 200);
      apb(1'b1, A_RTC, 32'h1);
      rtc_run <= 1'b0;
      expect_rst("osc fail", HOLD, RTC_RESET_FLAG_BIT, 60);
      conclude();
   end
endmodule : flash_rtc_soft_reset_sources_test
`default_nettype wire
